//--- lf_ctrl_defines.vh
// constants for the low-frequency initiator mode control block
`ifndef LF_CTRL_DEFINES_VH
`define LF_CTRL_DEFINES_VH
// operating modes
`define MODE_SLEEP 2'h0
`define MODE_STANDBY 2'h1
`define MODE_TRANSMIT 2'h2
`define MODE_DIAG 2'h3
// commands from the serial decoder
`define CMD_NONE 2'h0
`define CMD_TX 2'h1
`define CMD_DIAG 2'h2
// clock source detection
`define CLK_SRC_EXT 1'b0
`define CLK_SRC_XTAL 1'b1
`define DETECT_WINDOW 8'hc8
`define XTAL_EDGE_MIN 8'h05
// carrier frequency (kHz*10) limits and system clock rate in Hz
`define FREQ_FIXED_KHZ10 12'h4e2
`define FREQ_MIN_KHZ10 12'h44c
`define FREQ_MAX_KHZ10 12'h588
`define CLK_HZ 100000000
// sine amplitude code range, 0.25 Vpp steps: 1 .. 128
`define AMP_MIN 8'h01
`define AMP_MAX 8'h80
// square duty codes: 6.25, 12.5, 25, 50 percent of 16 phase slices
`define DUTY_0 4'h1
`define DUTY_1 4'h2
`define DUTY_2 4'h4
`define DUTY_3 4'h8
// data rate bit periods in clocks: 2, 4, 8 kbps
`define BIT_2K 16'hc350
`define BIT_4K 16'h61a8
`define BIT_8K 16'h30d4
// fsk: carrier edge counts per bit period at or above which a one is read
`define FSK_THRESH 16'h0100
`define FIFO_DEPTH 32
`define FIFO_AW 5
`endif

//--- lf_fifo.v
// small synchronous fifo for demodulated bits
`timescale 1ns/100ps
module lf_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire i_clk, // system clock
  input wire i_rst, // async reset, high
  input wire i_flush, // synchronous empty
  input wire i_in_valid, // write request
  output wire o_in_ready, // room available
  input wire [WIDTH-1:0] i_in_data, // write data
  output wire o_out_valid, // data available
  input wire i_out_ready, // reader takes data
  output wire [WIDTH-1:0] o_out_data // read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0] wr_ptr; // write index
  reg [AW-1:0] rd_ptr; // read index
  reg [AW:0] count; // words held
  wire do_wr; // accepted write
  wire do_rd; // accepted read
  assign o_in_ready = (count < DEPTH);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr];
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;
  // storage has no reset, only pointers and count do
  always @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
  // pointers and occupancy
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // lf_fifo

//--- lf_sync.v
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module lf_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk, // system clock
  input wire i_rst, // async reset, high
  input wire [WIDTH-1:0] i_async, // raw pins
  output reg [WIDTH-1:0] o_sync // synchronised levels
);
  reg [WIDTH-1:0] meta; // first stage, read only by second stage
  // two stages against metastability
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // lf_sync

//--- lf_initiator_mode_control.v
// mode control, clock detect, carrier, modulation and demodulated data path
`timescale 1ns/100ps
`include "lf_ctrl_defines.vh"
module lf_initiator_mode_control (
  input wire i_clk, // system clock 100 MHz
  input wire i_rst, // async reset, high
  input wire i_wake_pin, // wake pin, async
  input wire i_clk_in, // 2 MHz clock or resonator pin, async
  input wire i_logic_supply_low, // comparator: logic supply below threshold
  input wire i_driver_supply_low, // comparator: driver supply below threshold
  input wire i_temp_warn, // temperature pre-warning comparator
  input wire i_temp_over, // over-temperature comparator
  input wire i_over_current, // antenna over-current comparator
  input wire i_serial_error, // pulse: serial frame error from decoder
  input wire i_serial_active, // serial decoder sees chip select
  input wire i_sleep_cmd, // pulse: command to enter sleep
  input wire [1:0] i_cmd, // pulse code: enter transmit or diagnosis
  input wire i_cfg_fixed_freq, // 1: fixed 125 kHz carrier
  input wire [11:0] i_cfg_freq, // programmable carrier in 0.1 kHz
  input wire i_cfg_sine, // 1: sine, 0: square
  input wire [7:0] i_cfg_amp, // sine amplitude code
  input wire [1:0] i_cfg_duty, // square duty select
  input wire [7:0] i_cfg_ask_depth, // ask depth 0..255 = 0..100%
  input wire [1:0] i_cfg_mod, // 0 none, 1 ask, 2 psk
  input wire i_cfg_load, // pulse: latch config into active set
  input wire i_mod_data, // modulation data, async pin
  input wire [15:0] i_tx_len, // carrier half-periods per sequence
  input wire i_rx_fsk, // 1: fsk demod selected, 0: ask
  input wire [1:0] i_rx_rate, // 0:2k 1:4k 2:8k
  input wire i_amplitude_rx_input, // ask comparator level, async
  input wire i_frequency_rx_input, // fsk limiter level, async
  input wire i_diag_short_supply, // comparator: output stuck high
  input wire i_diag_short_gnd, // comparator: output stuck low
  input wire i_diag_current_seen, // comparator: antenna current present
  input wire i_diag_res_ok, // comparator: resonance within window
  input wire i_data_ready, // host side takes demod bit
  output reg [1:0] o_mode, // current operating mode
  output reg o_serial_enable, // serial slave allowed to answer
  output reg o_synth_on, // frequency synthesizer powered
  output reg o_clk_src, // detected clock source
  output reg o_clk_locked, // detection finished
  output reg o_drv_en, // driver stages enabled (else hi-z)
  output reg o_drv1, // driver 1 phase drive
  output reg o_drv2, // driver 2 phase drive
  output reg [7:0] o_amp_level, // current amplitude level to dac
  output reg o_data_out, // demodulated data output pin
  output reg o_data_valid, // demod data valid
  output reg [7:0] o_flags, // sticky failure flags
  output reg [2:0] o_diag_result // short supply, short gnd, open/resonance
);
  localparam ST_DIAG_LEN = 16'h0400; // diagnosis duration in clocks
  wire [4:0] pins_s; // synchronised pins
  wire wake_s; // wake pin
  wire clk_in_s; // clock pin
  wire mod_s; // modulation data
  wire arx_s; // ask input
  wire frx_s; // fsk input
  reg wake_d; // previous wake
  reg clkin_d; // previous clock pin
  reg frx_d; // previous fsk
  reg [1:0] next_mode; // next mode
  reg [15:0] tick; // general counter for tx/diag
  reg [7:0] det_cnt; // detection window counter
  reg [7:0] edge_cnt; // edges in detection window
  reg cfg_fixed; // active config copy
  reg [11:0] cfg_freq; // active frequency
  reg cfg_sine; // active waveform
  reg [7:0] cfg_amp; // active amplitude
  reg [1:0] cfg_duty; // active duty
  reg [7:0] cfg_depth; // active ask depth
  reg [1:0] cfg_mod; // active modulation
  reg [31:0] phase; // carrier phase accumulator
  wire [31:0] step; // phase increment
  wire [11:0] freq_use; // clamped selected frequency
  wire [3:0] slice; // 16 slices of a carrier cycle
  reg [3:0] duty_w; // square high slices
  reg [15:0] bit_len; // rx bit period
  reg [15:0] bit_cnt; // rx bit timer
  reg [15:0] hi_cnt; // ask high samples / fsk edges
  wire rx_bit; // decided bit
  wire fifo_in_ready; // fifo has room
  wire fifo_out_valid; // fifo has data
  wire fifo_out_data; // fifo head
  wire bit_done; // bit period ended
  wire next_phase_msb; // msb after the next step
  wire [31:0] phase_sum; // next accumulator
  lf_sync #(.WIDTH(5)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_wake_pin, i_clk_in, i_mod_data, i_amplitude_rx_input, i_frequency_rx_input}),
    .o_sync(pins_s)
  );
  assign {wake_s, clk_in_s, mod_s, arx_s, frx_s} = pins_s;
  // edge history on synchronised pins
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_d <= 1'b0;
      clkin_d <= 1'b0;
      frx_d <= 1'b0;
    end else begin
      wake_d <= wake_s;
      clkin_d <= clk_in_s;
      frx_d <= frx_s;
    end
  end
  // mode transitions
  always @* begin
    next_mode = o_mode;
    case (o_mode)
      `MODE_SLEEP: begin
        if (wake_s && !wake_d) begin
          next_mode = `MODE_STANDBY;
        end
      end
      `MODE_STANDBY: begin
        if (i_sleep_cmd) begin
          next_mode = `MODE_SLEEP;
        end else if (i_cmd == `CMD_TX && o_clk_locked) begin
          next_mode = `MODE_TRANSMIT;
        end else if (i_cmd == `CMD_DIAG && o_clk_locked) begin
          next_mode = `MODE_DIAG;
        end
      end
      `MODE_TRANSMIT: begin
        // back to standby when done or on a supply or temperature flag
        if (i_sleep_cmd) begin
          next_mode = `MODE_SLEEP;
        end else if (tick >= i_tx_len || o_flags[1:0] != 2'h0 || o_flags[3:2] != 2'h0) begin
          next_mode = `MODE_STANDBY;
        end
      end
      `MODE_DIAG: begin
        if (i_sleep_cmd) begin
          next_mode = `MODE_SLEEP;
        end else if (tick >= ST_DIAG_LEN) begin
          next_mode = `MODE_STANDBY;
        end
      end
      default: next_mode = `MODE_SLEEP;
    endcase
  end
  // mode register and per-mode outputs; supply faults abort a transmit
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= `MODE_SLEEP;
      o_serial_enable <= 1'b0;
      o_synth_on <= 1'b0;
      o_drv_en <= 1'b0;
      tick <= 16'h0000;
    end else begin
      o_mode <= next_mode;
      // serial off and synth off in sleep
      o_serial_enable <= (next_mode != `MODE_SLEEP);
      o_synth_on <= (next_mode != `MODE_SLEEP) && o_clk_locked;
      // drivers hi-z outside transmit and diagnosis
      o_drv_en <= (next_mode == `MODE_TRANSMIT) || (next_mode == `MODE_DIAG);
      if (next_mode != o_mode) begin
        tick <= 16'h0000;
      end else if (o_mode == `MODE_TRANSMIT) begin
        // counts carrier half-periods via phase msb change
        if (phase[31] != next_phase_msb) begin
          tick <= tick + 16'h0001;
        end
      end else if (o_mode == `MODE_DIAG) begin
        tick <= tick + 16'h0001;
      end
    end
  end
  // count clock pin edges to tell a 2 MHz clock from a resonator
  // a resonator that has not started shows few edges; the 2 MHz source many
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      det_cnt <= 8'h00;
      edge_cnt <= 8'h00;
      o_clk_src <= `CLK_SRC_EXT;
      o_clk_locked <= 1'b0;
    end else if (o_mode == `MODE_SLEEP) begin
      det_cnt <= 8'h00;
      edge_cnt <= 8'h00;
      o_clk_locked <= 1'b0;
    end else if (!o_clk_locked) begin
      det_cnt <= det_cnt + 8'h01;
      if (clk_in_s && !clkin_d && edge_cnt != 8'hff) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
      // pick the source once the window closes
      if (det_cnt == `DETECT_WINDOW) begin
        o_clk_locked <= 1'b1;
        o_clk_src <= (edge_cnt >= `XTAL_EDGE_MIN) ? `CLK_SRC_EXT : `CLK_SRC_XTAL;
      end
    end
  end
  // active config latched in standby, held during a sequence
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_fixed <= 1'b1;
      cfg_freq <= `FREQ_FIXED_KHZ10;
      cfg_sine <= 1'b0;
      cfg_amp <= `AMP_MIN;
      cfg_duty <= 2'h3;
      cfg_depth <= 8'h00;
      cfg_mod <= 2'h0;
    end else if (o_mode == `MODE_SLEEP) begin
      cfg_fixed <= 1'b1;
      cfg_freq <= `FREQ_FIXED_KHZ10;
      cfg_sine <= 1'b0;
      cfg_amp <= `AMP_MIN;
      cfg_duty <= 2'h3;
      cfg_depth <= 8'h00;
      cfg_mod <= 2'h0;
    end else if (i_cfg_load && o_mode != `MODE_TRANSMIT) begin
      cfg_fixed <= i_cfg_fixed_freq;
      cfg_freq <= i_cfg_freq;
      cfg_sine <= i_cfg_sine;
      cfg_amp <= (i_cfg_amp < `AMP_MIN) ? `AMP_MIN :
        ((i_cfg_amp > `AMP_MAX) ? `AMP_MAX : i_cfg_amp);
      cfg_duty <= i_cfg_duty;
      cfg_depth <= i_cfg_ask_depth;
      cfg_mod <= i_cfg_mod;
    end
  end
  assign freq_use = cfg_fixed ? `FREQ_FIXED_KHZ10 :
    ((cfg_freq < `FREQ_MIN_KHZ10) ? `FREQ_MIN_KHZ10 :
    ((cfg_freq > `FREQ_MAX_KHZ10) ? `FREQ_MAX_KHZ10 : cfg_freq));
  // step = f * 2^32 / clk; f in 0.1 kHz units, so 100 Hz * code
  assign step = step_calc(freq_use);
  function [31:0] step_calc;
    input [11:0] f;
    reg [63:0] t;
    reg [63:0] q;
    begin
      t = ({52'h0, f} * 64'd100) << 32;
      // quotient stays below 2^32 for the clamped range, so the cut is safe
      q = t / `CLK_HZ;
      step_calc = q[31:0];
    end
  endfunction
  assign phase_sum = phase + step;
  assign next_phase_msb = phase_sum[31];
  assign slice = phase[31:28];
  // carrier accumulator runs only when the synthesizer is on
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 32'h00000000;
    end else if (!o_synth_on) begin
      phase <= 32'h00000000;
    end else begin
      phase <= phase_sum;
    end
  end
  always @* begin
    case (cfg_duty)
      2'h0: duty_w = `DUTY_0;
      2'h1: duty_w = `DUTY_1;
      2'h2: duty_w = `DUTY_2;
      2'h3: duty_w = `DUTY_3;
      default: duty_w = `DUTY_3;
    endcase
  end
  // driver waveform: full bridge, driver 2 in anti-phase
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drv1 <= 1'b0;
      o_drv2 <= 1'b0;
      o_amp_level <= 8'h00;
    end else if (o_mode == `MODE_TRANSMIT) begin
      // psk inverts phase on data one
      if (cfg_sine) begin
        // sine: half-cycle sign; dac centres on mid-supply
        o_drv1 <= slice[3] ^ (cfg_mod == 2'h2 && mod_s);
      end else begin
        o_drv1 <= (slice < duty_w) ^ (cfg_mod == 2'h2 && mod_s);
      end
      o_drv2 <= !o_drv1;
      // ask scales amplitude by depth while data is low
      if (cfg_mod == 2'h1 && !mod_s) begin
        o_amp_level <= cfg_sine ? (cfg_amp - mult8(cfg_amp, cfg_depth)) :
          (8'hff - cfg_depth);
      end else begin
        o_amp_level <= cfg_sine ? cfg_amp : 8'hff;
      end
    end else if (o_mode == `MODE_DIAG) begin
      o_drv1 <= slice[3];
      o_drv2 <= !slice[3];
      o_amp_level <= `AMP_MIN;
    end else begin
      o_drv1 <= 1'b0;
      o_drv2 <= 1'b0;
      o_amp_level <= 8'h00;
    end
  end
  function [7:0] mult8;
    input [7:0] a;
    input [7:0] b;
    reg [15:0] p;
    begin
      p = {8'h00, a} * {8'h00, b};
      mult8 = p[15:8];
    end
  endfunction
  always @* begin
    case (i_rx_rate)
      2'h0: bit_len = `BIT_2K;
      2'h1: bit_len = `BIT_4K;
      2'h2: bit_len = `BIT_8K;
      default: bit_len = `BIT_8K;
    endcase
  end
  assign bit_done = (bit_cnt >= bit_len - 16'h0001);
  // fsk one when many edges, ask one when mostly high
  assign rx_bit = i_rx_fsk ? (hi_cnt >= `FSK_THRESH) : (hi_cnt >= {1'b0, bit_len[15:1]});
  // receive integrator, only while a sequence is active
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
    end else if (o_mode != `MODE_TRANSMIT || bit_done) begin
      bit_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
    end else begin
      bit_cnt <= bit_cnt + 16'h0001;
      if (i_rx_fsk ? (frx_s && !frx_d) : arx_s) begin
        hi_cnt <= hi_cnt + 16'h0001;
      end
    end
  end
  lf_fifo #(.WIDTH(1), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_flush(o_mode == `MODE_SLEEP),
    .i_in_valid(o_mode == `MODE_TRANSMIT && bit_done),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_bit),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_data_ready && o_data_valid),
    .o_out_data(fifo_out_data)
  );
  // registered data pin; defaults low while the fifo is empty
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data_out <= 1'b0;
      o_data_valid <= 1'b0;
    end else begin
      o_data_out <= fifo_out_valid ? fifo_out_data : 1'b0;
      o_data_valid <= fifo_out_valid && !(i_data_ready && o_data_valid);
    end
  end
  // sticky flags; clear wins in sleep except on a wake edge; cleared only by sleep
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flags <= 8'h00;
    end else if (o_mode == `MODE_SLEEP && !(wake_s && !wake_d)) begin
      o_flags <= 8'h00;
    end else begin
      o_flags <= o_flags | {1'b0, !fifo_in_ready && o_mode == `MODE_TRANSMIT,
        i_serial_error && i_serial_active, i_over_current, i_temp_over, i_temp_warn,
        i_driver_supply_low, i_logic_supply_low};
    end
  end
  // diagnosis latches antenna faults at end of window
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_diag_result <= 3'h0;
    end else if (o_mode == `MODE_SLEEP) begin
      o_diag_result <= 3'h0;
    end else if (o_mode == `MODE_DIAG && tick == ST_DIAG_LEN - 16'h0001) begin
      o_diag_result <= {i_diag_short_supply, i_diag_short_gnd,
        !i_diag_current_seen || !i_diag_res_ok};
    end
  end
endmodule // lf_initiator_mode_control

//--- lf_mode_assertions.sv
// port assertions for the low-frequency mode control block
`timescale 1ns/100ps
module lf_mode_checker (
  input wire i_clk, // system clock
  input wire i_rst, // async reset
  input wire i_wake_pin, // wake pin
  input wire i_logic_supply_low, // logic supply low
  input wire i_driver_supply_low, // driver supply low
  input wire i_sleep_cmd, // sleep command
  input wire [1:0] i_cmd, // mode command
  input wire [1:0] o_mode, // mode
  input wire o_serial_enable, // serial on
  input wire o_synth_on, // synth on
  input wire o_clk_locked, // clock found
  input wire o_drv_en, // drivers on
  input wire o_drv1, // driver 1
  input wire o_drv2, // driver 2
  input wire [7:0] o_flags // flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // wake edge while asleep
  sequence s_wake;
    o_mode == 2'h0 && $rose(i_wake_pin);
  endsequence
  // an active mode drops into sleep
  sequence s_sleep_entry;
    o_mode != 2'h0 ##1 o_mode == 2'h0;
  endsequence
  AST_SLEEP_OUTS: assert property (o_mode == 2'h0 |-> !o_drv_en && !o_synth_on)
    else $error("sleep left drivers or synth on");
  AST_SLEEP_SERIAL: assert property (o_mode == 2'h0 |-> !o_serial_enable)
    else $error("serial active in sleep");
  AST_SLEEP_CLEAR: assert property (s_sleep_entry |-> ##[0:1] o_flags == 8'h00)
    else $error("flags kept on sleep entry");
  AST_WAKE_EXIT: assert property (s_wake |-> ##[1:6] o_mode == 2'h1)
    else $error("wake edge did not reach standby");
  AST_SLEEP_STAYS: assert property (o_mode == 2'h0 |=> o_mode inside {2'h0, 2'h1})
    else $error("sleep left for an active mode");
  AST_STANDBY_OUTS: assert property (o_mode == 2'h1 |-> !o_drv_en && o_serial_enable)
    else $error("standby outputs wrong");
  AST_TX_OUTS: assert property (o_mode == 2'h2 |-> o_drv_en && o_synth_on && o_serial_enable)
    else $error("transmit outputs wrong");
  AST_DIAG_OUTS: assert property (o_mode == 2'h3 |-> o_drv_en && o_serial_enable)
    else $error("diagnosis outputs wrong");
  AST_LOGIC_UV: assert property (o_mode != 2'h0 && i_logic_supply_low |-> ##[1:4] o_flags[0])
    else $error("logic undervoltage not flagged");
  AST_DRV_UV: assert property (o_mode != 2'h0 && i_driver_supply_low |-> ##[1:4] o_flags[1])
    else $error("driver undervoltage not flagged");
  AST_CMD_TX: assert property (o_mode == 2'h1 && o_clk_locked && i_cmd == 2'h1 && !i_sleep_cmd
    |=> o_mode == 2'h2)
    else $error("transmit command not taken");
  AST_SLEEP_CMD: assert property (o_mode != 2'h0 && i_sleep_cmd |=> o_mode == 2'h0)
    else $error("sleep command not taken");
  // two cycles in a row transmitting
  sequence s_tx_run;
    o_mode == 2'h2 ##1 o_mode == 2'h2;
  endsequence
  AST_DRV_BRIDGE: assert property (s_tx_run |-> o_drv2 == !$past(o_drv1))
    else $error("driver 2 not in anti-phase");
  AST_DRV_IDLE: assert property (!o_drv_en |=> !o_drv1 && !o_drv2)
    else $error("driver toggled while disabled");
endmodule // lf_mode_checker
bind lf_initiator_mode_control lf_mode_checker u_lf_mode_checker (.i_clk(i_clk), .i_rst(i_rst),
  .i_wake_pin(i_wake_pin), .i_logic_supply_low(i_logic_supply_low),
  .i_driver_supply_low(i_driver_supply_low), .i_sleep_cmd(i_sleep_cmd), .i_cmd(i_cmd),
  .o_mode(o_mode), .o_serial_enable(o_serial_enable), .o_synth_on(o_synth_on),
  .o_clk_locked(o_clk_locked), .o_drv_en(o_drv_en), .o_flags(o_flags), .o_drv1(o_drv1),
  .o_drv2(o_drv2));

//--- lf_host_model.sv
// host side model: external clock pin and demod data pickup
`timescale 1ns/100ps
module lf_host_model (
  input wire i_clk, // system clock
  input wire i_run, // let the external clock run
  input wire i_stall, // hold off data pickup
  output logic o_clk_in, // external clock to device
  output logic o_data_ready // host takes a demod bit
);
  // external clock source
  // stands low when stopped so detection sees no stray edges
  initial begin
    o_clk_in = 1'b0;
    forever begin
      #62.5;
      o_clk_in = i_run ? ~o_clk_in : 1'b0;
    end
  end
  always @(negedge i_clk) o_data_ready <= ~i_stall;
endmodule // lf_host_model

//--- lf_initiator_mode_control_test.sv
// self-checking bench for the mode control block
`timescale 1ns/100ps
`include "lf_ctrl_defines.vh"
module lf_initiator_mode_control_test;
  logic i_clk, i_rst, i_wake_pin, i_clk_in, i_logic_supply_low, i_driver_supply_low;
  logic i_temp_warn, i_temp_over, i_over_current, i_serial_error, i_serial_active;
  logic i_sleep_cmd, i_cfg_fixed_freq, i_cfg_sine, i_cfg_load, i_mod_data, i_rx_fsk;
  logic i_amplitude_rx_input, i_frequency_rx_input, i_diag_short_supply, i_diag_short_gnd;
  logic i_diag_current_seen, i_diag_res_ok, i_data_ready;
  logic [1:0] i_cmd, i_cfg_duty, i_cfg_mod, i_rx_rate, o_mode;
  logic [11:0] i_cfg_freq;
  logic [7:0] i_cfg_amp, i_cfg_ask_depth, o_amp_level, o_flags;
  logic [15:0] i_tx_len;
  logic o_serial_enable, o_synth_on, o_clk_src, o_clk_locked, o_drv_en, o_drv1, o_drv2;
  logic o_data_out, o_data_valid, link_run, host_stall;
  logic [2:0] o_diag_result;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  // packed view: mode, driver enable, serial enable
  wire [7:0] st = {4'h0, o_mode, o_drv_en, o_serial_enable};
  // fault rows: comparator inputs and the sticky flags they leave
  logic [4:0] row_in [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [7:0] row_flags [5] = '{8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f};
  lf_initiator_mode_control u_lf_initiator_mode_control (.*);
  lf_host_model u_lf_host_model (.i_clk(i_clk), .i_run(link_run), .i_stall(host_stall),
    .o_clk_in(i_clk_in), .o_data_ready(i_data_ready));
  // system clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // verdict and end of run
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // compare one value
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a mode, then compare it
  task automatic wait_mode(input logic [1:0] m, input int n);
    int k;
    k = 0;
    while (o_mode !== m && k < n) begin
      @(negedge i_clk);
      k++;
    end
    check({6'h00, o_mode}, {6'h00, m});
  endtask
  // hang guard, well above the expected 15500 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    {i_wake_pin, i_logic_supply_low, i_driver_supply_low, i_temp_warn, i_temp_over} = '0;
    {i_over_current, i_serial_error, i_serial_active, i_sleep_cmd, i_cfg_sine} = '0;
    {i_cfg_load, i_mod_data, i_rx_fsk, i_amplitude_rx_input, i_frequency_rx_input} = '0;
    {i_diag_short_supply, i_diag_short_gnd, i_diag_current_seen, i_diag_res_ok} = '0;
    {i_cmd, i_cfg_duty, i_cfg_mod, i_rx_rate, i_cfg_freq, i_cfg_ask_depth} = '0;
    {link_run, host_stall} = '0;
    i_cfg_fixed_freq = 1'b1;
    i_cfg_amp = 8'h10;
    i_tx_len = 16'h0004;
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    check(st, 8'h00);
    check(o_flags, 8'h00);
    $display("reset test done");
    // wake with the external clock running
    link_run = 1'b1;
    @(negedge i_clk) i_wake_pin = 1'b1;
    wait_mode(2'h1, 10);
    check(st, 8'h05);
    // a command before lock is refused
    @(negedge i_clk) i_cmd = 2'h1;
    @(negedge i_clk) i_cmd = 2'h0;
    check(st, 8'h05);
    for (int k = 0; k < 300 && o_clk_locked !== 1'b1; k++) @(negedge i_clk);
    link_run = 1'b0;
    check({7'h00, o_clk_locked}, 8'h01);
    check({7'h00, o_clk_src}, {7'h00, `CLK_SRC_EXT});
    $display("wake and clock test done");
    @(negedge i_clk) i_cfg_load = 1'b1;
    @(negedge i_clk) i_cfg_load = 1'b0;
    // transmit runs four half-periods then falls back
    @(negedge i_clk) i_cmd = 2'h1;
    @(negedge i_clk) i_cmd = 2'h0;
    check(st, 8'h0b);
    host_stall = 1'b1;
    wait_mode(2'h1, 3000);
    check(st, 8'h05);
    $display("transmit test done");
    // diagnosis holds for its full window
    @(negedge i_clk) i_cmd = 2'h2;
    @(negedge i_clk) i_cmd = 2'h0;
    check(st, 8'h0f);
    repeat (1000) @(negedge i_clk);
    check(st, 8'h0f);
    wait_mode(2'h1, 100);
    check({5'h00, o_diag_result}, 8'h01);
    $display("diagnosis test done");
    // one fault at a time, flags accumulate
    for (int i = 0; i < 5; i++) begin
      @(negedge i_clk);
      {i_over_current, i_temp_over, i_temp_warn, i_driver_supply_low, i_logic_supply_low}
        = row_in[i];
      repeat (4) @(negedge i_clk);
      {i_over_current, i_temp_over, i_temp_warn, i_driver_supply_low, i_logic_supply_low}
        = 5'h00;
      check(o_flags, row_flags[i]);
    end
    i_serial_active = 1'b1;
    @(negedge i_clk) i_serial_error = 1'b1;
    @(negedge i_clk) i_serial_error = 1'b0;
    repeat (3) @(negedge i_clk);
    i_serial_active = 1'b0;
    check(o_flags, 8'h3f);
    $display("flag test done");
    // sticky flags abort a transmit at once, then sleep and a command while asleep
    @(negedge i_clk) i_cmd = 2'h1;
    @(negedge i_clk) i_cmd = 2'h0;
    wait_mode(2'h1, 5);
    repeat (50) @(negedge i_clk);
    @(negedge i_clk) i_sleep_cmd = 1'b1;
    @(negedge i_clk) i_sleep_cmd = 1'b0;
    repeat (2) @(negedge i_clk);
    check(st, 8'h00);
    check(o_flags, 8'h00);
    @(negedge i_clk) i_cmd = 2'h1;
    @(negedge i_clk) i_cmd = 2'h0;
    check(st, 8'h00);
    $display("sleep test done");
    // second wake with the pin clock stopped: resonator assumed
    i_wake_pin = 1'b0;
    repeat (2) @(negedge i_clk);
    i_wake_pin = 1'b1;
    wait_mode(2'h1, 10);
    for (int k = 0; k < 300 && o_clk_locked !== 1'b1; k++) @(negedge i_clk);
    check({7'h00, o_clk_src}, {7'h00, `CLK_SRC_XTAL});
    $display("resonator test done");
    // sine ask at half depth, one 8 kbps bit received, then sleep mid sequence
    i_cfg_sine = 1'b1;
    i_cfg_mod = 2'h1;
    i_cfg_ask_depth = 8'h80;
    i_rx_rate = 2'h2;
    i_amplitude_rx_input = 1'b1;
    i_tx_len = 16'h0028;
    host_stall = 1'b0;
    @(negedge i_clk) i_cfg_load = 1'b1;
    @(negedge i_clk) i_cfg_load = 1'b0;
    @(negedge i_clk) i_cmd = 2'h1;
    @(negedge i_clk) i_cmd = 2'h0;
    @(negedge i_clk);
    check(o_amp_level, 8'h08);
    for (int k = 0; k < 14000 && o_data_valid !== 1'b1; k++) @(negedge i_clk);
    check({6'h00, o_data_valid, o_data_out}, 8'h03);
    check(st, 8'h0b);
    @(negedge i_clk) i_sleep_cmd = 1'b1;
    @(negedge i_clk) i_sleep_cmd = 1'b0;
    check(st, 8'h00);
    $display("demodulation test done");
    complete_run();
  end
endmodule // lf_initiator_mode_control_test
